// ### hdl/scanned_display_zero_blank.sv
// scanned seven-digit display controller with leading-zero suppression
//
// The placing of the registers and the APB slave port were chosen for this implementation.

module scanned_display_zero_blank #(
  parameter int SCAN_DIV    = scan_display_pkg::SCAN_DIV,
  parameter int GUARD_CYC   = scan_display_pkg::GUARD_CYC,
  parameter int ONESHOT_CYC = scan_display_pkg::ONESHOT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  bcdIn,
  input  wire logic        gateTrigger,
  output logic      [6:0]  segLitN,
  output logic      [6:0]  digitEn,
  output logic      [3:0]  muxSel,
  output logic             muxOddEven,
  output logic             gateIndicator
);
  localparam int DIV_W = $clog2(SCAN_DIV);

  typedef struct packed {
    logic [DIV_W-1:0]                    prescale;
    logic [3:0]                          scanCount;
    logic                                anyNonzero;
    logic                                suppressEn;
    logic [3:0]                          bcdMeta;
    logic [3:0]                          bcdSync;
    logic                                trigMeta;
    logic                                trigSync;
    logic [6:0]                          segN;
    logic [6:0]                          digitEn;
    logic [3:0]                          muxSel;
    logic                                muxOddEven;
    logic                                gateInd;
    logic                                lampTest;
    logic                                blankIn;
    logic [scan_display_pkg::RES_W-1:0]  resMask;
    scan_display_pkg::bus_state_t        busState;
    logic                                pready;
    logic                                pslverr;
    logic [31:0]                         prdata;
  } top_state_t;

  localparam top_state_t ST_RESET = '{
    segN:     scan_display_pkg::SEG_ALL_OFF,
    busState: scan_display_pkg::BUS_IDLE,
    default:  '0
  };

  top_state_t  st;
  top_state_t  nxt;
  scan_link_if lnk ();

  logic       tick;
  logic       detValid;
  logic [2:0] frame;
  logic [7:0] frameLines;
  logic       inDigitFrame;
  logic       bcdNonzero;
  logic       midFrameZero;
  logic       setupPhase;
  logic       accessDone;
  logic [31:0] rdWord;
  logic       rdErr;

  // ----------------------------------------------------------------
  // helper modules
  // ----------------------------------------------------------------
  assign lnk.bcd      = st.bcdSync;
  assign lnk.lampTest = st.lampTest;
  assign lnk.blankIn  = st.blankIn;
  assign lnk.rippleBlankReq = st.suppressEn;
  assign lnk.trigger  = st.trigSync;

  segment_decoder u_segment_decoder (
    .lnk (lnk)
  );

  indicator_one_shot #(
    .PULSE_CYC (ONESHOT_CYC)
  ) u_indicator_one_shot (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .lnk     (lnk)
  );

  // ----------------------------------------------------------------
  // scan timing and frame decode
  // ----------------------------------------------------------------
  // detValid stays low for the first cycles of each step: the address just
  // moved and the synchronised digit still shows the old value
  always_comb begin
    tick         = (st.prescale == DIV_W'(SCAN_DIV - 1));
    detValid     = (st.prescale >= DIV_W'(GUARD_CYC));
    frame        = st.scanCount[3:1];
    frameLines   = 8'h01 << frame;
    inDigitFrame = !frameLines[0];
    bcdNonzero   = (st.bcdSync != 4'h0);
    midFrameZero = tick && (st.scanCount == 4'h0);
  end

  // ----------------------------------------------------------------
  // register slave decode
  // ----------------------------------------------------------------
  // read data is captured in the setup cycle, so status is a snapshot
  always_comb begin
    setupPhase = psel && !penable;
    accessDone = psel && penable && st.pready;
    rdWord     = 32'h0000_0000;
    rdErr      = 1'b0;
    if (paddr == scan_display_pkg::ADDR_CTRL) begin
      rdWord[scan_display_pkg::CTRL_LAMP_BIT]  = st.lampTest;
      rdWord[scan_display_pkg::CTRL_BLANK_BIT] = st.blankIn;
      rdWord[scan_display_pkg::CTRL_RES_LSB +: scan_display_pkg::RES_W] = st.resMask;
    end else if (paddr == scan_display_pkg::ADDR_STATUS) begin
      rdWord[scan_display_pkg::STATUS_FRAME_LSB +: 3] = frame;
      rdWord[scan_display_pkg::STATUS_ANYNZ_BIT]      = st.anyNonzero;
      rdWord[scan_display_pkg::STATUS_SUPP_BIT]       = st.suppressEn;
      rdWord[scan_display_pkg::STATUS_GATE_BIT]       = st.gateInd;
      rdWord[scan_display_pkg::STATUS_SCAN_LSB +: 4]  = st.scanCount;
    end else begin
      rdErr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt = st;

    // scan divider and counter, wraps after sixteen states
    if (tick) begin
      nxt.prescale  = '0;
      nxt.scanCount = st.scanCount + 4'h1;
    end else begin
      nxt.prescale = st.prescale + DIV_W'(1);
    end

    // pin synchronisers, first stage feeds only the second
    nxt.bcdMeta  = bcdIn;
    nxt.bcdSync  = st.bcdMeta;
    nxt.trigMeta = gateTrigger;
    nxt.trigSync = st.trigMeta;

    // any-nonzero latch, a set in the same cycle beats the clear
    if (st.scanCount == 4'h1) begin
      nxt.anyNonzero = 1'b0;
    end
    if (inDigitFrame && detValid && bcdNonzero) begin
      nxt.anyNonzero = 1'b1;
    end

    // suppression flop: loaded once per sequence, cleared by ripple output
    if (midFrameZero) begin
      nxt.suppressEn = st.anyNonzero;
    end else if (inDigitFrame && detValid && lnk.rippleOut) begin
      nxt.suppressEn = 1'b0;
    end

    // display and chain address drive
    nxt.segN    = lnk.segN;
    nxt.digitEn = frameLines[7:1] & ~st.resMask;
    // active-low frame lines are ANDed in pairs, i.e. ORed when active high
    for (int k = 0; k < 4; k++) begin
      nxt.muxSel[k] = frameLines[2*k] | frameLines[2*k+1];
    end
    nxt.muxOddEven = st.scanCount[0];
    nxt.gateInd    = st.trigSync | lnk.pulse;

    // register slave, one access cycle with no wait states
    case (st.busState)
      scan_display_pkg::BUS_IDLE: begin
        if (setupPhase) begin
          nxt.busState = scan_display_pkg::BUS_ACCESS;
          nxt.pready   = 1'b1;
          nxt.prdata   = pwrite ? 32'h0000_0000 : rdWord;
          nxt.pslverr  = rdErr;
        end
      end
      scan_display_pkg::BUS_ACCESS: begin
        if (accessDone) begin
          nxt.busState = scan_display_pkg::BUS_IDLE;
          nxt.pready   = 1'b0;
          nxt.pslverr  = 1'b0;
          nxt.prdata   = 32'h0000_0000;
          // status writes are ignored without error
          if (pwrite && paddr == scan_display_pkg::ADDR_CTRL) begin
            if (pstrb[0]) begin
              nxt.lampTest = pwdata[scan_display_pkg::CTRL_LAMP_BIT];
              nxt.blankIn  = pwdata[scan_display_pkg::CTRL_BLANK_BIT];
            end
            if (pstrb[1]) begin
              nxt.resMask = pwdata[scan_display_pkg::CTRL_RES_LSB +: scan_display_pkg::RES_W];
            end
          end
        end
      end
      default: begin
        nxt.busState = scan_display_pkg::BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= ST_RESET;
    end else if (ce) begin
      st <= nxt;
    end
  end

  // outputs straight from the state register
  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign segLitN       = st.segN;
  assign digitEn       = st.digitEn;
  assign muxSel        = st.muxSel;
  assign muxOddEven    = st.muxOddEven;
  assign gateIndicator = st.gateInd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seqMidFrameZero;
    ce && midFrameZero;
  endsequence

  sequence seqDigitNonzero;
    ce && inDigitFrame && detValid && bcdNonzero;
  endsequence

  property propSuppressLoad;
    @(posedge clk_sys) disable iff (rst)
    seqMidFrameZero |=> (st.suppressEn == $past(st.anyNonzero));
  endproperty

  AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    ce && tick |=> st.scanCount == 4'($past(st.scanCount) + 4'h1) && st.prescale == '0)
    else $error("scan counter did not step on tick");

  AST_FRAME_ONEHOT: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot(frameLines) && frameLines[frame])
    else $error("frame lines not one-hot");

  AST_FRAME_ZERO_DARK: assert property (@(posedge clk_sys) disable iff (rst)
    ce && frameLines[0] |=> digitEn == 7'h00)
    else $error("digit enabled in frame zero");

  AST_MUX_PAIR: assert property (@(posedge clk_sys) disable iff (rst)
    ce && (frame == 3'h3) |=> muxSel == 4'h2 && muxOddEven == $past(st.scanCount[0]))
    else $error("chain address wrong for frame three");

  AST_SEG_EIGHT: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !st.blankIn && !st.lampTest && st.bcdSync == 4'h8 |=> segLitN == 7'h00)
    else $error("digit eight not fully lit");

  AST_LAMP: assert property (@(posedge clk_sys) disable iff (rst)
    ce && st.lampTest && !st.blankIn |=> segLitN == scan_display_pkg::SEG_ALL_ON)
    else $error("lamp test did not light all segments");

  AST_BLANK: assert property (@(posedge clk_sys) disable iff (rst)
    ce && st.blankIn |=> segLitN == scan_display_pkg::SEG_ALL_OFF)
    else $error("blank did not darken segments");

  AST_RIPPLE_BLANK: assert property (@(posedge clk_sys) disable iff (rst)
    ce && st.suppressEn && !st.lampTest && st.bcdSync == 4'h0
    |=> segLitN == scan_display_pkg::SEG_ALL_OFF)
    else $error("suppressed zero not blanked");

  AST_DIGIT_ONEHOT: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot0(digitEn))
    else $error("more than one digit driver active");

  AST_FRAME_ADV: assert property (@(posedge clk_sys) disable iff (rst)
    ce && tick && st.scanCount[0] |=> frame == 3'($past(frame) + 3'h1))
    else $error("frame did not advance in order");

  AST_LATCH_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    ce && st.scanCount == 4'h1 |=> !st.anyNonzero)
    else $error("latch not cleared in late frame zero");

  AST_LATCH_SET: assert property (@(posedge clk_sys) disable iff (rst)
    seqDigitNonzero |=> st.anyNonzero [*1] ##1 (!ce || st.anyNonzero || st.scanCount == 4'h2))
    else $error("nonzero digit did not set latch");

  AST_GUARD: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !detValid && !st.anyNonzero |=> !st.anyNonzero)
    else $error("latch set during scan pulse");

  AST_SUPP_LOAD: assert property (propSuppressLoad)
    else $error("suppression not loaded at frame zero midpoint");

  AST_SUPP_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    seqDigitNonzero and (st.suppressEn && !st.blankIn && !midFrameZero) |=> !st.suppressEn)
    else $error("first nonzero digit did not end suppression");

  AST_SUPP_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !st.suppressEn && !midFrameZero |=> !st.suppressEn)
    else $error("suppression re-enabled within sequence");

  AST_INDICATOR: assert property (@(posedge clk_sys) disable iff (rst)
    ce && st.trigSync |=> gateIndicator ##1 (!ce || gateIndicator))
    else $error("indicator not driven by trigger");

  AST_RES_MASK: assert property (@(posedge clk_sys) disable iff (rst)
    ce && st.resMask[0] |=> !digitEn[0])
    else $error("masked digit still driven");

  AST_RESET: assert property (@(posedge clk_sys)
    rst |=> st.scanCount == 4'h0 && !st.anyNonzero && !st.suppressEn && digitEn == 7'h00)
    else $error("reset state wrong");
endmodule // scanned_display_zero_blank

// ### hdl/scan_display_pkg.sv
// constants shared by the scanned display controller and its helper modules
package scan_display_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ     = 200000;                    // clk_sys, 200 MHz
  localparam int SCAN_KHZ    = 200;                       // scan clock rate
  localparam int SCAN_DIV    = CLK_KHZ / SCAN_KHZ;        // cycles per scan step
  localparam int GUARD_CYC   = 4;                         // narrow scan pulse width
  localparam int ONESHOT_MS  = 30;                        // indicator stretch time
  localparam int ONESHOT_CYC = ONESHOT_MS * CLK_KHZ / 1000 * 1000; // ms times kHz

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // control register fields
  localparam int          CTRL_LAMP_BIT  = 0;
  localparam int          CTRL_BLANK_BIT = 1;
  localparam int          CTRL_RES_LSB   = 8;
  localparam int          RES_W          = 7;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // status register fields
  localparam int STATUS_FRAME_LSB = 0;
  localparam int STATUS_ANYNZ_BIT = 3;
  localparam int STATUS_SUPP_BIT  = 4;
  localparam int STATUS_GATE_BIT  = 5;
  localparam int STATUS_SCAN_LSB  = 8;

  // ----------------------------------------------------------------
  // display
  // ----------------------------------------------------------------
  localparam int         NUM_DIGITS  = 7;
  localparam logic [6:0] SEG_ALL_OFF = 7'h7f;             // active low, all dark
  localparam logic [6:0] SEG_ALL_ON  = 7'h00;             // active low, shows eight
  // active-high font, bit order g f e d c b a, index is the bcd value
  localparam logic [9:0][6:0] SEG_FONT = {
    7'h6f, 7'h7f, 7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f
  };

  // bus phase of the register slave
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ACCESS = 1'b1
  } bus_state_t;

endpackage

// ### hdl/scan_link_if.sv
// carrier between the controller and its segment decoder and one-shot
interface scan_link_if;
  logic [3:0] bcd;
  logic       lampTest;
  logic       blankIn;
  logic       rippleBlankReq;
  logic [6:0] segN;
  logic       rippleOut;
  logic       trigger;
  logic       pulse;

  modport decoder (input bcd, input lampTest, input blankIn, input rippleBlankReq,
                   output segN, output rippleOut);
  modport shot    (input trigger, output pulse);
  modport ctrl    (output bcd, output lampTest, output blankIn, output rippleBlankReq,
                   output trigger, input segN, input rippleOut, input pulse);
endinterface

// ### hdl/segment_decoder.sv
// bcd to seven segment decoder with lamp test, blanking and ripple blanking
module segment_decoder (
  scan_link_if.decoder lnk
);
  logic [6:0] font;
  logic       isZero;
  logic [6:0] segOut;
  logic       ripple;

  // blank overrides lamp test, lamp test overrides ripple blanking
  always_comb begin
    font   = 7'h00;
    isZero = (lnk.bcd == 4'h0);
    if (lnk.bcd <= 4'h9) begin
      font = scan_display_pkg::SEG_FONT[lnk.bcd];
    end
    ripple = !lnk.blankIn && !(lnk.rippleBlankReq && isZero);
    if (lnk.blankIn) begin
      segOut = scan_display_pkg::SEG_ALL_OFF;
    end else if (lnk.lampTest) begin
      segOut = scan_display_pkg::SEG_ALL_ON;
    end else if (lnk.rippleBlankReq && isZero) begin
      segOut = scan_display_pkg::SEG_ALL_OFF;
    end else begin
      segOut = ~font;
    end
  end

  assign lnk.segN      = segOut;
  assign lnk.rippleOut = ripple;
endmodule // segment_decoder

// ### hdl/indicator_one_shot.sv
// retriggerable one-shot that stretches the gate trigger for the indicator
module indicator_one_shot #(
  parameter int PULSE_CYC = scan_display_pkg::ONESHOT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  scan_link_if.shot lnk
);
  localparam int CNT_W = $clog2(PULSE_CYC + 1);

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } shot_state_t;

  shot_state_t st;
  shot_state_t nxt;

  // reload while the trigger is high, so the pulse outlasts the trigger
  always_comb begin
    nxt = st;
    if (lnk.trigger) begin
      nxt.count = CNT_W'(PULSE_CYC);
    end else if (st.count != '0) begin
      nxt.count = st.count - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= nxt;
    end
  end

  assign lnk.pulse = (st.count != '0);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SHOT_FIRE: assert property (@(posedge clk_sys) disable iff (rst)
    ce && lnk.trigger |=> lnk.pulse)
    else $error("one-shot did not fire on trigger");

  AST_SHOT_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && lnk.trigger) ##1 (ce && !lnk.trigger)[*8] |-> lnk.pulse)
    else $error("one-shot pulse ended too early");
endmodule // indicator_one_shot

// ### tb/chain_display_model.sv
// count chain multiplexer and display model for the scanned display bench
module chain_display_model (
  input  wire logic            clk_sys,
  input  wire logic            clr,
  input  wire logic [3:0]      muxSel,
  input  wire logic            muxOddEven,
  input  wire logic [6:0]      digitEn,
  input  wire logic [6:0]      segLitN,
  input  wire logic [6:0][3:0] digits,
  output logic      [3:0]      bcdIn,
  output logic      [6:0][6:0] shown,
  output logic      [6:0]      seen,
  output int                   multiOn
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] prevSel;
  logic       prevOe;
  logic       oddFrame;
  logic       nowOdd;
  logic [2:0] frame;

  // one select line spans two frames; the odd one begins when odd/even falls
  always_comb begin
    nowOdd = (muxSel == prevSel) ? (oddFrame ^ (prevOe & ~muxOddEven)) : 1'b0;
    frame  = 3'h0;
    for (int k = 0; k < 4; k++) begin
      if (muxSel[k]) begin
        frame = {k[1:0], nowOdd};
      end
    end
    bcdIn = (muxSel == 4'h0) ? 4'hf : 4'h0;
    if (frame != 3'h0) begin
      bcdIn = digits[frame - 3'h1];
    end
  end

  // last pattern of each powered digit; overlapping drivers are counted
  always @(posedge clk_sys) begin
    prevSel  <= muxSel;
    prevOe   <= muxOddEven;
    oddFrame <= nowOdd;
    if (clr) begin
      seen    <= 7'h00;
      multiOn <= 0;
    end else begin
      if ($countones(digitEn) > 1) begin
        multiOn <= multiOn + 1;
      end
      for (int i = 0; i < 7; i++) begin
        if (digitEn[i]) begin
          shown[i] <= segLitN;
          seen[i]  <= 1'b1;
        end
      end
    end
  end
endmodule // chain_display_model

// ### tb/tb_top.sv
// self-checking bench for the scanned display controller
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [6:0][3:0] d;    // index 0 is the first digit scanned
    logic [31:0]     ctrl;
  } row_t;

  localparam int   SEQ = 256; // 16 steps of 16 cycles
  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic            gateTrigger = 1'b0;
  logic            clr = 1'b0;
  logic            ce = 1'b1;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [6:0][3:0] digits = '0;
  logic [31:0]     prdata, rd;
  logic [6:0]      segLitN, digitEn, seen;
  logic [6:0][6:0] shown;
  logic [3:0]      muxSel, bcdIn;
  logic            pready, pslverr, muxOddEven, gateIndicator, err;
  int              err_count = 0;
  int              n_tests = 0;
  int              multiOn;
  row_t            rows [7] = '{
    '{28'h0000000, 32'h0000_0000}, '{28'h4032100, 32'h0000_0000},
    '{28'h3456789, 32'h0000_0000}, '{28'h7000000, 32'h0000_0000},
    '{28'h0000050, 32'h0000_0001}, '{28'h0000050, 32'h0000_0003},
    '{28'h1234560, 32'h0000_2a00}};

  // short scan and stretch counts keep the run brief
  scanned_display_zero_blank #(.SCAN_DIV(16), .GUARD_CYC(4), .ONESHOT_CYC(20)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bcdIn(bcdIn), .gateTrigger(gateTrigger),
    .segLitN(segLitN), .digitEn(digitEn), .muxSel(muxSel), .muxOddEven(muxOddEven),
    .gateIndicator(gateIndicator));

  chain_display_model u_chain (
    .clk_sys(clk_sys), .clr(clr), .muxSel(muxSel), .muxOddEven(muxOddEven),
    .digitEn(digitEn), .segLitN(segLitN), .digits(digits), .bcdIn(bcdIn),
    .shown(shown), .seen(seen), .multiOn(multiOn));

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // setup, then the access phase is held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && n++ < 50);
    rd  = prdata;
    err = pslverr;
    chk("pready", 32'(pready), 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // blank beats lamp test beats leading-zero blanking
  function automatic logic [6:0] exp_seg(row_t r, int i);
    logic lead;
    lead = 1'b1;
    for (int j = 0; j <= i; j++) begin
      lead = lead & (r.d[j] == 4'h0);
    end
    if (r.ctrl[1]) return 7'h7f;
    if (r.ctrl[0]) return 7'h00;
    if (lead && (r.d != '0)) return 7'h7f;
    return ~scan_display_pkg::SEG_FONT[r.d[i]];
  endfunction

  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // reset and registers, then the display table, then the gate lamp
  initial begin
    repeat (6) @(posedge clk_sys);
    chk("segLitN", 32'(segLitN), 32'h7f);
    chk("digitEn", 32'(digitEn), 32'h0);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, scan_display_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd & 32'h0000_0f1f, 32'h0);
    apb(1'b1, scan_display_pkg::ADDR_STATUS, 32'hffff_ffff);
    chk("roErr", 32'(err), 32'h0);
    apb(1'b1, 8'h08, 32'h3);
    chk("badWrErr", 32'(err), 32'h1);
    apb(1'b0, 8'h09, 32'h0);
    chk("badRdErr", 32'(err), 32'h1);
    chk("badRdData", rd, 32'h0);
    apb(1'b0, scan_display_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", rd, scan_display_pkg::CTRL_RESET);
    foreach (rows[r]) begin
      digits <= rows[r].d;
      apb(1'b1, scan_display_pkg::ADDR_CTRL, rows[r].ctrl);
      repeat (3 * SEQ) @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      repeat (2 * SEQ) @(posedge clk_sys);
      for (int i = 0; i < 7; i++) begin
        chk("digitSeen", 32'(seen[i]), 32'(!rows[r].ctrl[8 + i]));
        if (!rows[r].ctrl[8 + i]) begin
          chk("segments", 32'(shown[i]), 32'(exp_seg(rows[r], i)));
        end
      end
      chk("overlap", 32'(multiOn), 32'h0);
      apb(1'b0, scan_display_pkg::ADDR_STATUS, 32'h0);
      chk("frame", 32'(rd[2:0]), 32'(rd[11:9]));
    end
    gateTrigger <= 1'b1;
    @(posedge clk_sys);
    gateTrigger <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("gateStretch", 32'(gateIndicator), 32'h1);
    repeat (40) @(posedge clk_sys);
    chk("gateEnd", 32'(gateIndicator), 32'h0);
    // clock enable low freezes the scan; 100 cycles would cross several steps
    ce <= 1'b0;
    @(posedge clk_sys);
    rd = 32'({muxOddEven, muxSel, digitEn});
    repeat (100) @(posedge clk_sys);
    chk("ceFreeze", 32'({muxOddEven, muxSel, digitEn}), rd);
    ce <= 1'b1;
    // mid-run reset clears scan, latch, suppression and the control word
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("rstDigitEn", 32'(digitEn), 32'h0);
    apb(1'b0, scan_display_pkg::ADDR_STATUS, 32'h0);
    chk("rstStatus", rd & 32'h0000_0f1f, 32'h0);
    apb(1'b0, scan_display_pkg::ADDR_CTRL, 32'h0);
    chk("rstCtrl", rd, scan_display_pkg::CTRL_RESET);
    end_sim();
  end

  // hang guard, far beyond the ten thousand cycles the tests need
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule // tb_top
